// ---- hdl/audio_port_pkg.sv ----
// Shared constants for the serial audio port: formats, widths, timing, host register map.
// Assumes both ends run from ref_clk_i at the rate given below.
package audio_port_pkg;

	// ----------------------------------------
	// Formats and sample layout
	// ----------------------------------------
	typedef enum logic [1:0] {
		FMT_STD = 2'b00,
		FMT_LJ = 2'b01,
		FMT_DSP = 2'b10
	} fmt_t;

	localparam int SAMPLE_W = 24;
	localparam int PAIR_W = 2 * SAMPLE_W;
	localparam int FIFO_DEPTH = 16;

	localparam logic [1:0] DLY_LJ = 2'h0;
	localparam logic [1:0] DLY_ONE = 2'h1;
	localparam logic [1:0] DLY_TWO = 2'h2;

	localparam logic [5:0] WBITS_8 = 6'h08;
	localparam logic [5:0] WBITS_16 = 6'h10;
	localparam logic [5:0] WBITS_20 = 6'h14;
	localparam logic [5:0] WBITS_24 = 6'h18;

	function automatic logic [5:0] width_of(input logic [1:0] sel);
		case (sel)
			2'b00: width_of = WBITS_8;
			2'b01: width_of = WBITS_16;
			2'b10: width_of = WBITS_20;
			default: width_of = WBITS_24;
		endcase
	endfunction

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 25;
	localparam int BCLK_PERIOD_NS = 200;
	localparam int BCLK_HALF_CYC = BCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
	localparam int BCLK_HALF_MIN = 4;

	// ----------------------------------------
	// Host register map
	// ----------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_SLOT = 8'h04;
	localparam logic [7:0] REG_LEFT = 8'h08;
	localparam logic [7:0] REG_RIGHT = 8'h0C;
	localparam logic [7:0] REG_STATUS = 8'h10;

	localparam int CTRL_EN = 0;
	localparam int CTRL_FMT_LSB = 1;
	localparam int CTRL_WSEL_LSB = 3;
	localparam int CTRL_DSP2 = 5;
	localparam int CTRL_FALL = 6;
	localparam logic [6:0] CTRL_RST = 7'h18;
	localparam logic [7:0] SLOT_RST = 8'h20;
	localparam logic [7:0] SLOT_MIN = 8'h1B;

endpackage

// ---- hdl/audio_link_if.sv ----
// Three-wire serial audio link between the audio clock master and the slave port.
// Assumes the bench joins the two ends through one instance of this interface.
`timescale 1ns/10ps
`default_nettype none
interface audio_link_if;
	logic audio_bit_clock;
	logic audio_frame_sync;
	logic audio_data;

	modport dev (
		input audio_bit_clock,
		input audio_frame_sync,
		output audio_data
	);

	modport host (
		output audio_bit_clock,
		output audio_frame_sync,
		input audio_data
	);
endinterface
`default_nettype wire

// ---- hdl/audio_tx_device.sv ----
// Slave serial audio transmitter with its sample FIFO.
// Assumes bit clock and frame sync come from the master and are asynchronous to ref_clk_i.
//
// The register addresses and the plain strobed port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------
// Sample FIFO
// ----------------------------------------
module audio_sample_fifo #(
	parameter int WIDTH = 48,
	parameter int DEPTH = 16
) (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int PTR_W = $clog2(DEPTH);
	localparam int CNT_W = $clog2(DEPTH + 1);
	localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);

	generate
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
			$error("fifo depth must be a power of two, at least 2");
		end
	endgenerate

	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [PTR_W-1:0] wr_ptr_ff;
	logic [PTR_W-1:0] rd_ptr_ff;
	logic [CNT_W-1:0] count_ff;
	logic [CNT_W-1:0] nxt_count;
	logic ready_ff;
	logic push;
	logic pop;

	assign push = in_valid_i & ready_ff;
	assign pop = out_ready_i & (count_ff != '0);
	assign in_ready_o = ready_ff;
	assign out_valid_o = (count_ff != '0);
	assign out_data_o = mem_ff[rd_ptr_ff];

	always_comb begin
		nxt_count = count_ff;
		if (push && !pop) begin
			nxt_count = count_ff + 1'b1;
		end else if (pop && !push) begin
			nxt_count = count_ff - 1'b1;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (push) begin
			mem_ff[wr_ptr_ff] <= in_data_i;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff <= '0;
			ready_ff <= 1'b0;
		end else begin
			wr_ptr_ff <= wr_ptr_ff + PTR_W'(push);
			rd_ptr_ff <= rd_ptr_ff + PTR_W'(pop);
			count_ff <= nxt_count;
			// Registered so the port ready comes from a flop
			ready_ff <= (nxt_count != FULL_CNT);
		end
	end
endmodule

// ----------------------------------------
// Slave transmitter
// ----------------------------------------
module audio_tx_device #(
	parameter int DEPTH = audio_port_pkg::FIFO_DEPTH
) (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic [audio_port_pkg::SAMPLE_W-1:0] left_i,
	input wire logic [audio_port_pkg::SAMPLE_W-1:0] right_i,
	input wire logic sample_valid_i,
	output logic sample_ready_o,
	input wire audio_port_pkg::fmt_t fmt_i,
	input wire logic [1:0] width_sel_i,
	input wire logic dsp_second_i,
	input wire logic capture_fall_i,
	output logic underrun_o,
	audio_link_if.dev link
);
	import audio_port_pkg::*;

	logic bclk_meta_ff, bclk_sync_ff, bclk_prev_ff;
	logic fs_meta_ff, fs_sync_ff, fs_prev_ff;
	logic [PAIR_W-1:0] fifo_data;
	logic fifo_valid;
	logic launch, ev_left, ev_right, fs_edge;
	logic [1:0] dly;
	logic [5:0] wbits, total;
	logic [SAMPLE_W-1:0] mask, left_m, right_m;
	logic [PAIR_W-1:0] word;
	logic [PAIR_W-1:0] shreg_ff;
	logic [SAMPLE_W-1:0] right_hold_ff;
	logic [5:0] cnt_ff;
	logic [1:0] wait_ff;
	logic dout_ff, underrun_ff;

	audio_sample_fifo #(.WIDTH(PAIR_W), .DEPTH(DEPTH)) u_fifo (
		.ref_clk_i(ref_clk_i),
		.sys_rst_i(sys_rst_i),
		.in_valid_i(sample_valid_i),
		.in_ready_o(sample_ready_o),
		.in_data_i({left_i, right_i}),
		.out_valid_o(fifo_valid),
		.out_ready_i(ev_left),
		.out_data_o(fifo_data)
	);

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			bclk_meta_ff <= 1'b0;
			bclk_sync_ff <= 1'b0;
			bclk_prev_ff <= 1'b0;
			fs_meta_ff <= 1'b0;
			fs_sync_ff <= 1'b0;
			fs_prev_ff <= 1'b0;
		end else begin
			bclk_meta_ff <= link.audio_bit_clock;
			bclk_sync_ff <= bclk_meta_ff;
			bclk_prev_ff <= bclk_sync_ff;
			fs_meta_ff <= link.audio_frame_sync;
			fs_sync_ff <= fs_meta_ff;
			fs_prev_ff <= fs_sync_ff;
		end
	end

	// ----------------------------------------
	// Event decode
	// ----------------------------------------
	always_comb begin
		// Data changes on the edge opposite the capture edge
		launch = capture_fall_i ? (bclk_sync_ff & ~bclk_prev_ff) : (~bclk_sync_ff & bclk_prev_ff);
		fs_edge = fs_sync_ff ^ fs_prev_ff;
		wbits = width_of(width_sel_i);
		mask = ~(24'hFFFFFF >> wbits);
		left_m = fifo_valid ? (fifo_data[PAIR_W-1:SAMPLE_W] & mask) : '0;
		right_m = fifo_valid ? (fifo_data[SAMPLE_W-1:0] & mask) : '0;
		ev_left = 1'b0;
		ev_right = 1'b0;
		dly = DLY_ONE;
		total = wbits;
		word = {right_hold_ff, 24'h000000};
		case (fmt_i)
			FMT_DSP: begin
				ev_left = fs_sync_ff & ~fs_prev_ff;
				dly = dsp_second_i ? DLY_TWO : DLY_ONE;
				total = 6'(wbits << 1);
				word = {left_m, 24'h000000} | ({right_m, 24'h000000} >> wbits);
			end
			FMT_LJ: begin
				ev_left = fs_edge & fs_sync_ff;
				ev_right = fs_edge & ~fs_sync_ff;
				dly = DLY_LJ;
				if (ev_left) begin
					word = {left_m, 24'h000000};
				end
			end
			default: begin
				ev_left = fs_edge & ~fs_sync_ff;
				ev_right = fs_edge & fs_sync_ff;
				dly = DLY_ONE;
				if (ev_left) begin
					word = {left_m, 24'h000000};
				end
			end
		endcase
	end

	// ----------------------------------------
	// Serialiser
	// ----------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			shreg_ff <= '0;
			cnt_ff <= '0;
			wait_ff <= '0;
			dout_ff <= 1'b0;
		end else if (ev_left || ev_right) begin
			// A new sync edge restarts the word whatever the idle count was
			wait_ff <= dly;
			if (dly == DLY_LJ) begin
				dout_ff <= word[PAIR_W-1];
				shreg_ff <= word << 1;
				cnt_ff <= total - 6'h01;
			end else begin
				dout_ff <= 1'b0;
				shreg_ff <= word;
				cnt_ff <= total;
			end
		end else if (launch) begin
			if (wait_ff != '0) begin
				wait_ff <= wait_ff - 2'h1;
				if (wait_ff == DLY_ONE) begin
					dout_ff <= shreg_ff[PAIR_W-1];
					shreg_ff <= shreg_ff << 1;
					cnt_ff <= cnt_ff - 6'h01;
				end else begin
					dout_ff <= 1'b0;
				end
			end else if (cnt_ff != '0) begin
				dout_ff <= shreg_ff[PAIR_W-1];
				shreg_ff <= shreg_ff << 1;
				cnt_ff <= cnt_ff - 6'h01;
			end else begin
				dout_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			right_hold_ff <= '0;
			underrun_ff <= 1'b0;
		end else begin
			if (ev_left) begin
				right_hold_ff <= right_m;
			end
			// Empty FIFO sends silence rather than stalling the frame
			underrun_ff <= ev_left & ~fifo_valid;
		end
	end

	assign link.audio_data = dout_ff;
	assign underrun_o = underrun_ff;
endmodule
`default_nettype wire

// ---- hdl/audio_rx_host.sv ----
// Audio clock master: makes bit clock and frame sync, captures the data line.
// Assumes software drives the plain register port on ref_clk_i.
`timescale 1ns/10ps
`default_nettype none
module audio_rx_host #(
	parameter int HALF = audio_port_pkg::BCLK_HALF_CYC
) (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic [audio_port_pkg::ADDR_W-1:0] addr_i,
	input wire logic [audio_port_pkg::DATA_W-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [audio_port_pkg::DATA_W-1:0] rdata_o,
	audio_link_if.host link
);
	import audio_port_pkg::*;

	generate
		if (HALF < BCLK_HALF_MIN) begin : g_bad_half
			$error("bit clock half period too short for the slave latency");
		end
	endgenerate

	localparam logic [7:0] HALF_LAST = 8'(HALF - 1);

	logic [6:0] ctrl_ff;
	logic [7:0] slot_ff;
	logic [SAMPLE_W-1:0] left_ff, right_ff;
	logic [15:0] frames_ff;
	logic [DATA_W-1:0] rdata_ff;
	logic [7:0] hcnt_ff;
	logic bclk_ff, fs_ff, ch_ff;
	logic [8:0] pos_ff;
	logic [PAIR_W-1:0] rx_ff;
	logic din_meta_ff, din_sync_ff;
	logic en, fall, tick, launch, wrap, ch_new, in_word, word_end;
	fmt_t fmt;
	logic [1:0] dly;
	logic [5:0] wbits, nbits, sh;
	logic [7:0] slot_eff;
	logic [8:0] len, rel;
	logic [PAIR_W-1:0] full, lj_full, lj_left;

	always_comb begin
		en = ctrl_ff[CTRL_EN];
		fall = ctrl_ff[CTRL_FALL];
		fmt = fmt_t'(ctrl_ff[CTRL_FMT_LSB +: 2]);
		wbits = width_of(ctrl_ff[CTRL_WSEL_LSB +: 2]);
		sh = 6'(SAMPLE_W) - wbits;
		slot_eff = (slot_ff < SLOT_MIN) ? SLOT_MIN : slot_ff;
		len = (fmt == FMT_DSP) ? {slot_eff, 1'b0} : {1'b0, slot_eff};
		nbits = (fmt == FMT_DSP) ? 6'(wbits << 1) : wbits;
		dly = (fmt == FMT_LJ) ? DLY_LJ : ((fmt == FMT_DSP && ctrl_ff[CTRL_DSP2]) ? DLY_TWO : DLY_ONE);
		tick = en && (hcnt_ff == HALF_LAST);
		launch = tick && ((~bclk_ff) == fall);
		wrap = (pos_ff == len - 9'h001);
		ch_new = (fmt == FMT_DSP) ? 1'b0 : ~ch_ff;
		rel = pos_ff - {7'h00, dly};
		in_word = (pos_ff >= {7'h00, dly}) && (rel < {3'h0, nbits});
		word_end = in_word && (rel == {3'h0, nbits} - 9'h001);
		full = {rx_ff[PAIR_W-2:0], din_sync_ff};
		lj_full = full << sh;
		lj_left = (full >> wbits) << sh;
	end

	// ----------------------------------------
	// Register port
	// ----------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			ctrl_ff <= CTRL_RST;
			slot_ff <= SLOT_RST;
		end else if (wr_i) begin
			if (addr_i == REG_CTRL) begin
				ctrl_ff <= wdata_i[6:0];
			end else if (addr_i == REG_SLOT) begin
				slot_ff <= wdata_i[7:0];
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			rdata_ff <= '0;
		end else if (rd_i) begin
			if (addr_i == REG_CTRL) begin
				rdata_ff <= {25'h0000000, ctrl_ff};
			end else if (addr_i == REG_SLOT) begin
				rdata_ff <= {24'h000000, slot_ff};
			end else if (addr_i == REG_LEFT) begin
				rdata_ff <= {8'h00, left_ff};
			end else if (addr_i == REG_RIGHT) begin
				rdata_ff <= {8'h00, right_ff};
			end else if (addr_i == REG_STATUS) begin
				rdata_ff <= {16'h0000, frames_ff};
			end else begin
				rdata_ff <= '0;
			end
		end else begin
			rdata_ff <= '0;
		end
	end

	// ----------------------------------------
	// Clock and frame generation
	// ----------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			hcnt_ff <= '0;
			bclk_ff <= 1'b0;
			fs_ff <= 1'b0;
			ch_ff <= 1'b1;
			pos_ff <= '0;
		end else if (!en) begin
			// Idle sync level makes the first left slot start with a real edge
			hcnt_ff <= '0;
			bclk_ff <= fall;
			fs_ff <= (fmt != FMT_LJ) && (fmt != FMT_DSP);
			ch_ff <= 1'b1;
			pos_ff <= len - 9'h001;
		end else begin
			hcnt_ff <= tick ? 8'h00 : hcnt_ff + 8'h01;
			if (tick) begin
				bclk_ff <= ~bclk_ff;
			end
			if (launch) begin
				if (wrap) begin
					pos_ff <= '0;
					ch_ff <= ch_new;
					if (fmt == FMT_LJ) begin
						fs_ff <= ~ch_new;
					end else if (fmt == FMT_DSP) begin
						fs_ff <= 1'b1;
					end else begin
						// Reserved code runs as standard, as the slave does
						fs_ff <= ch_new;
					end
				end else begin
					// Idle clocks fill the rest of the slot
					pos_ff <= pos_ff + 9'h001;
					if (fmt == FMT_DSP) begin
						fs_ff <= 1'b0;
					end
				end
			end
		end
	end

	// ----------------------------------------
	// Capture
	// ----------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			din_meta_ff <= 1'b0;
			din_sync_ff <= 1'b0;
		end else begin
			din_meta_ff <= link.audio_data;
			din_sync_ff <= din_meta_ff;
		end
	end

	// Sampled half a bit late to absorb both sync chains
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			rx_ff <= '0;
			left_ff <= '0;
			right_ff <= '0;
			frames_ff <= '0;
		end else if (launch && in_word) begin
			rx_ff <= full;
			if (word_end) begin
				if (fmt == FMT_DSP) begin
					left_ff <= lj_left[SAMPLE_W-1:0];
					right_ff <= lj_full[SAMPLE_W-1:0];
					frames_ff <= frames_ff + 16'h0001;
				end else if (!ch_ff) begin
					left_ff <= lj_full[SAMPLE_W-1:0];
				end else begin
					right_ff <= lj_full[SAMPLE_W-1:0];
					frames_ff <= frames_ff + 16'h0001;
				end
			end
		end
	end

	assign link.audio_bit_clock = bclk_ff;
	assign link.audio_frame_sync = fs_ff;
	assign rdata_o = rdata_ff;
endmodule
`default_nettype wire

// ---- dv/audio_link_monitor.sv ----
// Link checker: watches the three link wires beside the device's static configuration.
// Assumes the host runs its default divider, so one bit period is 8 reference cycles.
`timescale 1ns/10ps
`default_nettype none
module audio_link_monitor (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic audio_bit_clock,
	input wire logic audio_frame_sync,
	input wire logic audio_data,
	input wire audio_port_pkg::fmt_t fmt_i,
	input wire logic [1:0] width_sel_i,
	input wire logic dsp_second_i,
	input wire logic capture_fall_i
);
	import audio_port_pkg::*;
	// ----------------------------------------
	// Bit position tracking
	// ----------------------------------------
	logic bclk_ff, fs_ff, launch, sync_evt;
	logic [2:0] quiet_ff;
	logic [7:0] idx_ff, idx, wbits, first_bit, last_bit;
	always_comb begin
		launch = capture_fall_i ? (audio_bit_clock & ~bclk_ff) : (~audio_bit_clock & bclk_ff);
		sync_evt = (fmt_i == FMT_DSP) ? (audio_frame_sync & ~fs_ff) : (audio_frame_sync ^ fs_ff);
		idx = sync_evt ? 8'h00 : ((idx_ff == 8'hFF) ? 8'hFF : idx_ff + 8'h01);
		wbits = (width_sel_i == 2'h0) ? 8'h08 : (width_sel_i == 2'h1) ? 8'h10 :
			(width_sel_i == 2'h2) ? 8'h14 : 8'h18;
		first_bit = (fmt_i == FMT_LJ) ? 8'h00 : (fmt_i == FMT_DSP) ? 8'h01 + {7'h0, dsp_second_i} : 8'h01;
		last_bit = first_bit + ((fmt_i == FMT_DSP) ? {wbits[6:0], 1'h0} : wbits) - 8'h01;
	end
	always_ff @(posedge ref_clk_i) begin
		bclk_ff <= audio_bit_clock;
		fs_ff <= audio_frame_sync;
	end
	// A stopped bit clock ends the slot, so an edge made while the host is idle is no short slot
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i)
			quiet_ff <= 3'h0;
		else if (audio_bit_clock != bclk_ff)
			quiet_ff <= 3'h0;
		else if (quiet_ff != 3'h7)
			quiet_ff <= quiet_ff + 3'h1;
	end
	// Saturating start value keeps the first sync after reset from looking like a short slot
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i)
			idx_ff <= 8'hFF;
		else if (launch)
			idx_ff <= idx;
		else if (quiet_ff == 3'h7)
			idx_ff <= 8'hFF;
	end
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (sys_rst_i);
	property p_bclk_high;
		$rose(audio_bit_clock) |=> audio_bit_clock [*3];
	endproperty
	a_bclk_high: assert property (p_bclk_high) else $error("bit clock high phase short");
	property p_bclk_low;
		$fell(audio_bit_clock) |=> !audio_bit_clock [*3];
	endproperty
	a_bclk_low: assert property (p_bclk_low) else $error("bit clock low phase short");
	property p_dsp_pulse;
		fmt_i == FMT_DSP && launch && $rose(audio_frame_sync) |-> audio_frame_sync [*8] ##1 !audio_frame_sync;
	endproperty
	a_dsp_pulse: assert property (p_dsp_pulse) else $error("sync pulse not one bit wide");
	property p_data_launch;
		$changed(audio_data) |-> $past(launch, 3);
	endproperty
	a_data_launch: assert property (p_data_launch) else $error("data moved off launch edge");
	property p_data_hold;
		$changed(audio_data) |=> $stable(audio_data) [*7];
	endproperty
	a_data_hold: assert property (p_data_hold) else $error("data bit shorter than a period");
	property p_idle_low;
		launch && (idx < first_bit || idx > last_bit) |-> ##3 !audio_data;
	endproperty
	a_idle_low: assert property (p_idle_low) else $error("data high outside word");
	property p_std_slot;
		fmt_i != FMT_DSP && launch && sync_evt |-> idx_ff >= 8'd26;
	endproperty
	a_std_slot: assert property (p_std_slot) else $error("channel slot too short");
	property p_dsp_frame;
		fmt_i == FMT_DSP && launch && sync_evt |-> idx_ff >= 8'd53;
	endproperty
	a_dsp_frame: assert property (p_dsp_frame) else $error("pulse frame too short");
endmodule
`default_nettype wire

// ---- dv/digital_audio_serial_port_bench.sv ----
// Bench: device end and clock-master host end joined by the link, host read over its register port.
// Assumes the host runs its default divider; every case starts from a fresh reset.
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin errors++; \
	$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp); end end
module digital_audio_serial_port_bench;
	import audio_port_pkg::*;
	logic ref_clk_i = 1'h0;
	logic sys_rst_i = 1'h1;
	logic [SAMPLE_W-1:0] left_i = '0, right_i = '0;
	logic sample_valid_i = 1'h0, sample_ready_o, underrun_o, dsp_second_i = 1'h0, capture_fall_i = 1'h0;
	fmt_t fmt_i = FMT_STD;
	logic [1:0] width_sel_i = 2'h3;
	logic [ADDR_W-1:0] addr_i = '0;
	logic [DATA_W-1:0] wdata_i = '0, rdata_o, ev;
	logic wr_i = 1'h0, rd_i = 1'h0, note_i = 1'h0, rd_seen = 1'h0, note_seen = 1'h0;
	logic [DATA_W-1:0] expq[$];
	logic [6:0] cfg[7] = '{7'h18, 7'h02, 7'h0C, 7'h74, 7'h56, 7'h5A, 7'h3C};
	logic [7:0] slot[7] = '{8'h20, 8'h1B, 8'h20, 8'h28, 8'h05, 8'h3C, 8'h1B};
	int errors = 0, compares = 0, seed = 65646, ucnt = 0;
	audio_link_if link();
	audio_tx_device u_audio_tx_device (.ref_clk_i, .sys_rst_i, .left_i, .right_i, .sample_valid_i,
		.sample_ready_o, .fmt_i, .width_sel_i, .dsp_second_i, .capture_fall_i, .underrun_o,
		.link(link.dev));
	audio_rx_host u_audio_rx_host (.ref_clk_i, .sys_rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
		.link(link.host));
	audio_link_monitor u_audio_link_monitor (.ref_clk_i, .sys_rst_i,
		.audio_bit_clock(link.audio_bit_clock), .audio_frame_sync(link.audio_frame_sync),
		.audio_data(link.audio_data), .fmt_i, .width_sel_i, .dsp_second_i, .capture_fall_i);
	always #12.5 ref_clk_i = ~ref_clk_i;
	// ----------------------------------------
	// Result watcher: read data stands only in the cycle after the strobe
	// ----------------------------------------
	always @(posedge ref_clk_i) begin
		rd_seen <= rd_i;
		note_seen <= note_i;
	end
	always @(negedge ref_clk_i) begin
		if (underrun_o === 1'h1)
			ucnt++;
		if (rd_seen && note_seen) begin
			ev = expq.pop_front();
			`CHK(rdata_o, ev)
		end
	end
	// ----------------------------------------
	// Bus and stream tasks
	// ----------------------------------------
	task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'h1;
		@(posedge ref_clk_i);
		wr_i <= 1'h0;
	endtask
	task automatic bus_rd(input logic [7:0] a, input logic nt, input logic [31:0] e,
		output logic [31:0] d);
		if (nt)
			expq.push_back(e);
		@(posedge ref_clk_i);
		addr_i <= a;
		rd_i <= 1'h1;
		note_i <= nt;
		@(posedge ref_clk_i);
		rd_i <= 1'h0;
		note_i <= 1'h0;
		@(negedge ref_clk_i);
		d = rdata_o;
	endtask
	task automatic push(input logic [23:0] l, input logic [23:0] r);
		@(posedge ref_clk_i);
		left_i <= l;
		right_i <= r;
		sample_valid_i <= 1'h1;
		do @(negedge ref_clk_i); while (sample_ready_o !== 1'h1);
		@(posedge ref_clk_i);
		sample_valid_i <= 1'h0;
	endtask
	task automatic give_verdict();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// ----------------------------------------
	// Cases: every format, width, MSB option and edge; one slot below the clamp
	// ----------------------------------------
	initial begin : main
		logic [31:0] d, l, r, m;
		logic [6:0] c;
		logic [23:0] lq[$], rq[$];
		int w, np, n;
		for (int s = 0; s < 7; s++) begin
			@(posedge ref_clk_i);
			c = cfg[s];
			sys_rst_i <= 1'h1;
			fmt_i <= fmt_t'(c[2:1]);
			width_sel_i <= c[4:3];
			dsp_second_i <= c[5];
			capture_fall_i <= c[6];
			repeat (6) @(posedge ref_clk_i);
			sys_rst_i <= 1'h0;
			if (s == 0) begin
				bus_rd(REG_CTRL, 1'h1, 32'h18, d);
				bus_rd(REG_SLOT, 1'h1, 32'h20, d);
				bus_wr(8'h14, 32'hFFFFFFFF);
				bus_rd(8'h14, 1'h1, 32'h0, d);
			end
			// Load the format while disabled so the idle clock and sync levels match it
			bus_wr(REG_CTRL, {25'h0, c[6:1], 1'h0});
			w = (c[4:3] == 2'h0) ? 8 : (c[4:3] == 2'h1) ? 16 : (c[4:3] == 2'h2) ? 20 : 24;
			m = 32'h00FFFFFF & ~((32'h1 << (24 - w)) - 32'h1);
			np = (s == 0) ? 16 : 3;
			lq.delete();
			rq.delete();
			for (int k = 0; k < np; k++) begin
				l = $random(seed);
				r = $random(seed);
				lq.push_back(l[23:0]);
				rq.push_back(r[23:0]);
				push(l[23:0], r[23:0]);
			end
			if (s == 0) begin
				repeat (2) @(negedge ref_clk_i);
				`CHK(sample_ready_o, 1'h0)
			end
			bus_wr(REG_SLOT, {24'h0, slot[s]});
			bus_rd(REG_SLOT, 1'h1, {24'h0, slot[s]}, d);
			bus_wr(REG_CTRL, {25'h0, c[6:1], 1'h1});
			ucnt = 0;
			for (int k = 1; k <= np + 1; k++) begin
				n = 0;
				do bus_rd(REG_STATUS, 1'h0, 32'h0, d); while (d[15:0] !== k[15:0] && n++ < 2000);
				if (n > 2000)
					errors++;
				l = (k <= np) ? {8'h0, lq[k-1]} & m : 32'h0;
				r = (k <= np) ? {8'h0, rq[k-1]} & m : 32'h0;
				bus_rd(REG_LEFT, 1'h1, l, d);
				bus_rd(REG_RIGHT, 1'h1, r, d);
			end
			`CHK(ucnt, 1)
		end
		give_verdict();
	end
	// Cases need about 22000 cycles; the limit leaves wide margin
	initial begin
		repeat (90000) @(posedge ref_clk_i);
		errors++;
		give_verdict();
	end
endmodule
`default_nettype wire
